// ---- hw/ssrx_pkg.sv ----
// Operation
// [R1] Master clock is selected baud tick divided by four
// [R2] Master samples data at divider value 2
// [R3] Master shifts receive register at divider value 3
// [R4] Master frame starts at shift strobe after enable
// [R5] Master shifts in bit from preceding sample
// [R6] Partner changes data on serial clock falling edge
// [R7] Master takes a single sample per bit
// [R8] Master buffers word, completes on instruction start
// [R9] Unread buffer at transfer flags overrun, overwrites
// [R10] Master clears receive enable after the frame
// [R11] Slave edge-detects external clock on CPU clock
// [R12] Slave starts with enable set and clock pulses
// [R13] Slave samples data while external clock low
// [R14] Slave shifts sampled bit on next shift strobe
// [R15] Slave buffers word, completes on instruction start
// [R16] Slave keeps enable set, continues on clocks
// [R17] Status updates only when receive complete fires
// [R18] Frame length from control settings, strobes counted
package ssrx_pkg;

  // ---------------------------------------------------------------
  // Sizes and divider values
  // ---------------------------------------------------------------
  localparam int          SSRX_DATA_W     = 8;
  localparam int          SSRX_FIFO_DEPTH = 16;
  localparam logic [1:0]  SSRX_DIV_LAST   = 2'h3;  // Divide by four
  localparam logic [1:0]  SSRX_SAMPLE_PRE = 2'h1;  // Tick here enters value 2
  localparam logic [1:0]  SSRX_SHIFT_PRE  = 2'h2;  // Tick here enters value 3
  localparam logic [1:0]  SSRX_DIV_RESET  = 2'h0;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [3:0]  SSRX_BITCNT_RESET = 4'h0;
  localparam logic        SSRX_SCLK_IDLE    = 1'b1;
  localparam logic        SSRX_FLAG_RESET   = 1'b0;
  localparam logic [7:0]  SSRX_WORD_RESET   = 8'h00;

  // ---------------------------------------------------------------
  // Receive state
  // ---------------------------------------------------------------
  typedef enum logic [0:0] {
    SSRX_IDLE = 1'b0,
    SSRX_RECV = 1'b1
  } ssrx_state_t;

endpackage

// ---- hw/ssrx_sync3.sv ----
`timescale 1ns/1ns
`default_nettype none
module ssrx_sync3 import ssrx_pkg::*; #(
  parameter logic INIT = 1'b1
) (
  input  wire logic i_ref_clk,
  input  wire logic i_nrst,
  input  wire logic i_async,
  output var  logic o_level
);

  logic ff1_reg;
  logic ff2_reg;
  logic ff3_reg;
  logic level_reg;

  // Three stages; the level moves only once stages two and three agree
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ff1_reg   <= INIT;
      ff2_reg   <= INIT;
      ff3_reg   <= INIT;
      level_reg <= INIT;
    end else begin
      ff1_reg <= i_async;
      ff2_reg <= ff1_reg;
      ff3_reg <= ff2_reg;
      if (ff2_reg == ff3_reg) begin
        level_reg <= ff3_reg;
      end
    end
  end

  assign o_level = level_reg;

endmodule
`default_nettype wire

// ---- hw/ssrx_fifo.sv ----
`timescale 1ns/1ns
`default_nettype none
module ssrx_fifo import ssrx_pkg::*; #(
  parameter int WIDTH = SSRX_DATA_W,
  parameter int DEPTH = SSRX_FIFO_DEPTH
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_nrst,
  input  wire logic             i_in_valid,
  output var  logic             o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output var  logic             o_out_valid,
  input  wire logic             i_out_ready,
  output var  logic [WIDTH-1:0] o_out_data
);

  // DEPTH must be a power of two so the pointers wrap by themselves
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = DEPTH[AW:0];

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wptr_reg,  wptr_next;
  logic [AW-1:0]    rptr_reg,  rptr_next;
  logic [AW:0]      count_reg, count_next;
  logic             out_valid_reg, out_valid_next;
  logic [WIDTH-1:0] out_data_reg,  out_data_next;
  logic             push;
  logic             pop;

  // Pointer, fill and output register update
  always_comb begin
    push           = i_in_valid && o_in_ready;
    pop            = (count_reg != '0) && (!out_valid_reg || i_out_ready);
    wptr_next      = push ? wptr_reg + 1'b1 : wptr_reg;
    rptr_next      = pop ? rptr_reg + 1'b1 : rptr_reg;
    count_next     = count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    out_valid_next = pop ? 1'b1 : (i_out_ready ? 1'b0 : out_valid_reg);
    out_data_next  = pop ? mem_reg[rptr_reg] : out_data_reg;
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wptr_reg      <= '0;
      rptr_reg      <= '0;
      count_reg     <= '0;
      out_valid_reg <= 1'b0;
      out_data_reg  <= '0;
    end else begin
      wptr_reg      <= wptr_next;
      rptr_reg      <= rptr_next;
      count_reg     <= count_next;
      out_valid_reg <= out_valid_next;
      out_data_reg  <= out_data_next;
    end
  end

  // Storage carries no reset; only valid words are ever read out
  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem_reg[wptr_reg] <= i_in_data;
    end
  end

  assign o_in_ready  = (count_reg != FULL_CNT);
  assign o_out_valid = out_valid_reg;
  assign o_out_data  = out_data_reg;

endmodule
`default_nettype wire

// ---- hw/ssrx_receiver.sv ----
`timescale 1ns/1ns
`default_nettype none
module ssrx_receiver import ssrx_pkg::*; #(
  parameter bit CHANNEL_SIX = 1'b0,
  parameter int DATA_W      = SSRX_DATA_W,
  parameter int FIFO_DEPTH  = SSRX_FIFO_DEPTH
) (
  input  wire logic              i_ref_clk,
  input  wire logic              i_nrst,
  input  wire logic              i_timer3_tick,
  input  wire logic              i_timer4_tick,
  input  wire logic              i_master_mode,
  input  wire logic [3:0]        i_bits_per_frame,
  input  wire logic              i_enable_set,
  input  wire logic              i_enable_clear,
  input  wire logic              i_instruction_start_strobe,
  input  wire logic              i_buffer_read,
  input  wire logic              i_status_clear,
  input  wire logic              i_serial_data_in_pin,
  input  wire logic              i_serial_clock_io_pin,
  output var  logic              o_serial_clock_io_pin,
  output var  logic              o_serial_clock_io_oe,
  output var  logic              o_receive_enable_flag,
  output var  logic [DATA_W-1:0] o_receive_buffer,
  output var  logic              o_buffer_unread,
  output var  logic              o_receive_complete,
  output var  logic              o_overrun_status,
  output var  logic              o_busy,
  output var  logic              o_stream_valid,
  input  wire logic              i_stream_ready,
  output var  logic [DATA_W-1:0] o_stream_data
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Zero or oversize lengths fall back to the full word
  function automatic logic [3:0] frame_len(input logic [3:0] cfg);
    if (cfg == 4'h0 || cfg > DATA_W[3:0]) begin
      return DATA_W[3:0];
    end
    return cfg;
  endfunction

  // LSB arrives first, so a short frame sits high and is moved down
  function automatic logic [DATA_W-1:0] align(input logic [DATA_W-1:0] w,
                                              input logic [3:0] len);
    return w >> (DATA_W[3:0] - len);
  endfunction

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic clk_lvl;
  logic data_lvl;

  ssrx_sync3 #(.INIT(1'b1)) u_sync_clk (
    .i_ref_clk (i_ref_clk),
    .i_nrst    (i_nrst),
    .i_async   (i_serial_clock_io_pin),
    .o_level   (clk_lvl)
  );

  ssrx_sync3 #(.INIT(1'b1)) u_sync_data (
    .i_ref_clk (i_ref_clk),
    .i_nrst    (i_nrst),
    .i_async   (i_serial_data_in_pin),
    .o_level   (data_lvl)
  );

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  ssrx_state_t       state_reg,    state_next;
  logic [1:0]        div_reg,      div_next;
  logic [3:0]        bitcnt_reg,   bitcnt_next;
  logic [DATA_W-1:0] shift_reg,    shift_next;
  logic [DATA_W-1:0] hold_reg,     hold_next;
  logic [DATA_W-1:0] buffer_reg,   buffer_next;
  logic              sample_reg,   sample_next;
  logic              clk_prev_reg, clk_prev_next;
  logic              enable_reg,   enable_next;
  logic              pending_reg,  pending_next;
  logic              unread_reg,   unread_next;
  logic              complete_reg, complete_next;
  logic              overrun_reg,  overrun_next;
  logic              sclk_reg,     sclk_next;
  logic              baud_tick;
  logic              sample_strobe;
  logic              shift_strobe;
  logic              frame_done;
  logic              transfer;
  logic              fifo_ready;
  logic              fifo_push;
  logic [3:0]        len;

  // Strobes from the divider or from the external clock level and rising edge
  always_comb begin
    baud_tick     = CHANNEL_SIX ? i_timer3_tick : i_timer4_tick;   // see [R1]
    len           = frame_len(i_bits_per_frame);                    // see [R18]
    if (i_master_mode) begin
      sample_strobe = baud_tick && (div_reg == SSRX_SAMPLE_PRE);    // see [R2]
      shift_strobe  = baud_tick && (div_reg == SSRX_SHIFT_PRE);     // see [R3]
    end else begin
      sample_strobe = !clk_lvl;                                     // see [R13]
      shift_strobe  = clk_lvl && !clk_prev_reg;                     // see [R11]
    end
  end

  // Frame sequencing, transfer to the buffer and status
  always_comb begin
    state_next    = state_reg;
    div_next      = div_reg;
    bitcnt_next   = bitcnt_reg;
    shift_next    = shift_reg;
    hold_next     = hold_reg;
    buffer_next   = buffer_reg;
    sample_next   = sample_reg;
    clk_prev_next = clk_lvl;
    enable_next   = enable_reg;
    pending_next  = pending_reg;
    unread_next   = unread_reg;
    complete_next = 1'b0;
    overrun_next  = overrun_reg;
    sclk_next     = SSRX_SCLK_IDLE;
    frame_done    = 1'b0;

    // Divider free-runs in master mode so the first strobe is defined
    if (i_master_mode && baud_tick) begin
      div_next = (div_reg == SSRX_DIV_LAST) ? SSRX_DIV_RESET : div_reg + 2'h1; // see [R1]
    end
    // One sample per bit in master mode; slave samples every cycle while clock is low and later ones overwrite, no voting
    if (sample_strobe) begin
      sample_next = data_lvl;                                       // see [R7]
    end

    unique case (state_reg)
      SSRX_IDLE: begin
        // Master waits for a free buffer path so a full FIFO stalls it
        if (i_master_mode && shift_strobe && enable_reg && !pending_reg && fifo_ready) begin
          state_next  = SSRX_RECV;                                  // see [R4]
          bitcnt_next = SSRX_BITCNT_RESET;
        end else if (!i_master_mode && shift_strobe && enable_reg) begin
          shift_next  = {sample_reg, shift_reg[DATA_W-1:1]};        // see [R12]
          bitcnt_next = 4'h1;
          if (len == 4'h1) begin
            frame_done = 1'b1;
          end else begin
            state_next = SSRX_RECV;
          end
        end
      end
      SSRX_RECV: begin
        if (shift_strobe) begin
          shift_next  = {sample_reg, shift_reg[DATA_W-1:1]};        // see [R5] [R14]
          bitcnt_next = bitcnt_reg + 4'h1;
          if (bitcnt_reg + 4'h1 == len) begin                       // see [R18]
            frame_done = 1'b1;
            state_next = SSRX_IDLE;
          end
        end
      end
    endcase

    // Serial clock is low for values 0 and 1, high for 2 and 3
    if (i_master_mode && state_next == SSRX_RECV) begin
      sclk_next = div_next[1];                                      // see [R4]
    end

    // A finished word waits in the hold register for instruction start
    if (frame_done) begin
      hold_next    = align(shift_next, len);
      pending_next = 1'b1;
    end
    if (frame_done && i_master_mode) begin
      enable_next = 1'b0;                                           // see [R10]
    end
    // Slave leaves enable untouched so further clocks start a new frame
    if (i_enable_clear) begin
      enable_next = 1'b0;
    end
    if (i_enable_set) begin
      enable_next = 1'b1;                                           // see [R16]
    end

    // Transfer, complete pulse and status all fall on one edge
    if (transfer) begin
      buffer_next   = hold_reg;                                     // see [R8] [R15]
      complete_next = 1'b1;
      pending_next  = frame_done;
      if (unread_reg || !fifo_ready) begin
        overrun_next = 1'b1;                                        // see [R9] [R17]
      end
    end else if (i_status_clear) begin
      overrun_next = 1'b0;
    end
    // New data beats a read in the same cycle
    if (transfer) begin
      unread_next = 1'b1;
    end else if (i_buffer_read) begin
      unread_next = 1'b0;
    end
  end

  assign transfer  = pending_reg && i_instruction_start_strobe;
  assign fifo_push = transfer;

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg    <= SSRX_IDLE;
      div_reg      <= SSRX_DIV_RESET;
      bitcnt_reg   <= SSRX_BITCNT_RESET;
      shift_reg    <= SSRX_WORD_RESET;
      hold_reg     <= SSRX_WORD_RESET;
      buffer_reg   <= SSRX_WORD_RESET;
      sample_reg   <= 1'b1;
      clk_prev_reg <= 1'b1;
      enable_reg   <= SSRX_FLAG_RESET;
      pending_reg  <= SSRX_FLAG_RESET;
      unread_reg   <= SSRX_FLAG_RESET;
      complete_reg <= SSRX_FLAG_RESET;
      overrun_reg  <= SSRX_FLAG_RESET;
      sclk_reg     <= SSRX_SCLK_IDLE;
    end else begin
      state_reg    <= state_next;
      div_reg      <= div_next;
      bitcnt_reg   <= bitcnt_next;
      shift_reg    <= shift_next;
      hold_reg     <= hold_next;
      buffer_reg   <= buffer_next;
      sample_reg   <= sample_next;
      clk_prev_reg <= clk_prev_next;
      enable_reg   <= enable_next;
      pending_reg  <= pending_next;
      unread_reg   <= unread_next;
      complete_reg <= complete_next;
      overrun_reg  <= overrun_next;
      sclk_reg     <= sclk_next;
    end
  end

  // ---------------------------------------------------------------
  // Stream buffer
  // ---------------------------------------------------------------
  // Slave mode cannot be stalled, so a full FIFO there counts as overrun
  ssrx_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_ref_clk   (i_ref_clk),
    .i_nrst      (i_nrst),
    .i_in_valid  (fifo_push),
    .o_in_ready  (fifo_ready),
    .i_in_data   (hold_reg),
    .o_out_valid (o_stream_valid),
    .i_out_ready (i_stream_ready),
    .o_out_data  (o_stream_data)
  );

  assign o_serial_clock_io_pin = sclk_reg;
  assign o_serial_clock_io_oe  = i_master_mode;                     // see [R11]
  assign o_receive_enable_flag = enable_reg;
  assign o_receive_buffer      = buffer_reg;
  assign o_buffer_unread       = unread_reg;
  assign o_receive_complete    = complete_reg;
  assign o_overrun_status      = overrun_reg;
  assign o_busy                = (state_reg == SSRX_RECV) || pending_reg;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);

  AST_DIV_WRAP: assert property (i_master_mode && baud_tick && div_reg == 2'h3 |=> div_reg == 2'h0) // see [R1]
    else $error("divider did not wrap after value 3");
  AST_SAMPLE_ONCE: assert property (i_master_mode && !sample_strobe |=> sample_reg == $past(sample_reg)) // see [R2] [R7]
    else $error("master sample changed outside value 2 strobe");
  AST_SHIFT_AT_3: assert property (i_master_mode && state_reg == SSRX_RECV && bitcnt_next != bitcnt_reg |=> div_reg == 2'h3) // see [R3]
    else $error("master shift outside divider value 3");
  AST_START: assert property (i_master_mode && state_reg == SSRX_IDLE && shift_strobe && enable_reg && !pending_reg && fifo_ready |=> state_reg == SSRX_RECV && o_serial_clock_io_oe) // see [R4]
    else $error("master frame failed to start");
  AST_SHIFT_DATA: assert property (state_reg == SSRX_RECV && shift_strobe |=> shift_reg[DATA_W-1] == $past(sample_reg)) // see [R5] [R14]
    else $error("shifted bit is not the sampled bit");
  AST_COMPLETE_ALIGN: assert property (o_receive_complete |-> $past(transfer)) // see [R8] [R15]
    else $error("receive complete not on instruction start");
  AST_OVERRUN: assert property (transfer && unread_reg |=> o_overrun_status && o_buffer_unread) // see [R9]
    else $error("overrun not flagged on unread buffer");
  AST_EN_CLEAR: assert property (i_master_mode && frame_done && !i_enable_set |=> !o_receive_enable_flag) // see [R10]
    else $error("master left enable set after frame");
  AST_SLAVE_KEEP: assert property (!i_master_mode && frame_done && !i_enable_clear |=> o_receive_enable_flag) // see [R16]
    else $error("slave cleared enable after frame");
  AST_SLAVE_SAMPLE: assert property (!i_master_mode && !clk_lvl |=> sample_reg == $past(data_lvl)) // see [R13]
    else $error("slave did not sample while clock low");
  AST_STATUS_AT_COMPLETE: assert property ($rose(o_overrun_status) |-> o_receive_complete) // see [R17]
    else $error("status changed without receive complete");
  // A frame never counts past its length, so a counter that runs past it shows up here
  AST_LEN: assert property (state_reg == SSRX_RECV |-> bitcnt_reg < len) // see [R18]
    else $error("frame ended at wrong bit count");

  COV_MASTER: cover property (i_master_mode && frame_done ##[1:40] o_receive_complete);
  COV_SLAVE: cover property (!i_master_mode && frame_done ##[1:40] o_receive_complete);
  COV_OVERRUN: cover property ($rose(o_overrun_status));
  COV_FULL: cover property (!fifo_ready);

endmodule
`default_nettype wire

// ---- bench/ssrx_partner.sv ----
`timescale 1ns/1ns
`default_nettype none
// Far-side transmitter: follows the device clock in master mode, makes its own in slave mode
module ssrx_partner (
  input  wire logic       i_ref_clk,
  input  wire logic       i_master_mode,
  input  wire logic       i_clk_wire,
  input  wire logic       i_go,
  input  wire logic [7:0] i_word,
  input  wire logic [3:0] i_len,
  output var  logic       o_data,
  output var  logic       o_sclk
);
  int   idx;
  logic rel;
  initial begin
    o_data = 1'b1;
    o_sclk = 1'b1;
    rel    = 1'b1;
  end
  // One frame per go pulse, LSB first; the slave clock stands still between frames
  always begin
    @(posedge i_ref_clk);
    if (i_go) begin
      rel = 1'b0;
      for (idx = 0; idx < i_len; idx++) begin
        if (i_master_mode) begin
          @(negedge i_clk_wire);
          #1 o_data = i_word[idx];
        end else begin
          #1 o_sclk = 1'b0;
          o_data = i_word[idx];
          // Slow phases: the device needs several CPU cycles per phase
          repeat (10) @(posedge i_ref_clk);
          #1 o_sclk = 1'b1;
          repeat (10) @(posedge i_ref_clk);
        end
      end
      repeat (12) @(posedge i_ref_clk);     // Hold the last bit past its sample
      rel = 1'b1;
    end else if (rel) begin
      #1 o_data = ~o_data;                  // Released line never shows a stale bit
    end
  end
endmodule
`default_nettype wire

// ---- bench/ssrx_receiver_tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module ssrx_receiver_tb_top;
  import ssrx_pkg::*;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic       clk = 1'b0, nrst = 1'b0, t3 = 1'b0, t4 = 1'b0, mode = 1'b1, m1 = 1'b0;
  logic [3:0] bpf = 4'h8, plen = 4'h8;
  logic       en_set = 1'b0, en_clr = 1'b0, rd = 1'b0, st_clr = 1'b0, s_rdy = 1'b0;
  logic       go = 1'b0;
  logic [7:0] pword = 8'h00;
  logic       sd, psclk, dclk, doe, flag, unread, cmpl, ovr, busy, s_val;
  logic [7:0] buf_q, s_data;
  wire        clk_wire = doe ? dclk : psclk;  // Shared clock pin level
  logic [2:0] cnt = 3'h0;
  int         fails = 0, n_tests = 0, cycles = 0;
  time        t_last = 0, period = 0;

  always #4 clk = ~clk;
  // Baud ticks every 4 cycles on the selected timer, a slower one on the other
  always @(posedge clk) begin
    cnt <= cnt + 3'h1;
    t4  <= #1 (cnt[1:0] == 2'h3);
    t3  <= #1 (cnt == 3'h1);
    m1  <= #1 (cnt == 3'h5);
  end
  // Period of the driven serial clock
  always @(negedge clk_wire) if (doe) begin
    period = $time - t_last;
    t_last = $time;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      report_and_stop();
    end
  end

  ssrx_receiver ssrx_receiver_inst (
    .i_ref_clk(clk), .i_nrst(nrst), .i_timer3_tick(t3), .i_timer4_tick(t4),
    .i_master_mode(mode), .i_bits_per_frame(bpf), .i_enable_set(en_set),
    .i_enable_clear(en_clr), .i_instruction_start_strobe(m1), .i_buffer_read(rd),
    .i_status_clear(st_clr), .i_serial_data_in_pin(sd), .i_serial_clock_io_pin(clk_wire),
    .o_serial_clock_io_pin(dclk), .o_serial_clock_io_oe(doe), .o_receive_enable_flag(flag),
    .o_receive_buffer(buf_q), .o_buffer_unread(unread), .o_receive_complete(cmpl),
    .o_overrun_status(ovr), .o_busy(busy), .o_stream_valid(s_val), .i_stream_ready(s_rdy),
    .o_stream_data(s_data));
  ssrx_partner ssrx_partner_inst (
    .i_ref_clk(clk), .i_master_mode(mode), .i_clk_wire(clk_wire), .i_go(go),
    .i_word(pword), .i_len(plen), .o_data(sd), .o_sclk(psclk));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk_bit(input logic exp, input logic got, input string what);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t %s exp %b got %b", $time, what, exp, got);
    end
  endtask
  task automatic chk_word(input logic [7:0] exp, input logic [7:0] got, input string what);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t %s exp %h got %h", $time, what, exp, got);
    end
  endtask
  task automatic pulse_go(input logic [7:0] w, input logic [3:0] n);
    pword = w;
    plen  = n;
    go    = 1'b1;
    step(1);
    go    = 1'b0;
  endtask
  task automatic pulse_en();
    en_set = 1'b1;
    step(1);
    en_set = 1'b0;
  endtask
  // Wait for receive complete; status must not move before it
  task automatic wait_cmpl();
    logic ov0, moved, seen;
    ov0 = ovr;
    moved = 1'b0;
    seen = 1'b0;
    for (int i = 0; i < 400 && !seen; i++) begin
      if (cmpl === 1'b1) seen = 1'b1;
      else begin
        if (ovr !== ov0) moved = 1'b1;
        step(1);
      end
    end
    chk_bit(1'b1, seen, "complete seen");
    chk_bit(1'b0, moved, "status early");
  endtask
  task automatic read_clear();
    rd = 1'b1;
    st_clr = 1'b1;
    step(1);
    rd = 1'b0;
    st_clr = 1'b0;
    step(1);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic master_basic();
    mode = 1'b1;
    pulse_go(8'hA5, 4'h8);
    step(20);
    chk_bit(1'b1, dclk, "clock idle without enable");
    chk_bit(1'b0, busy, "busy without enable");
    pulse_en();
    wait_cmpl();
    chk_word(8'hA5, buf_q, "master word");
    chk_bit(1'b0, flag, "enable cleared");
    chk_bit(1'b1, unread, "unread set");
    chk_bit(1'b0, ovr, "no overrun");
    chk_bit(1'b1, period == 128, "clock period 4 ticks");
    chk_bit(1'b1, doe, "master drives clock");
    read_clear();
    chk_bit(1'b0, unread, "unread cleared");
  endtask
  task automatic master_short_overrun();
    bpf = 4'h5;
    pulse_go(8'hEB, 4'h5);
    pulse_en();
    wait_cmpl();
    chk_word(8'h0B, buf_q, "short frame right aligned");
    bpf = 4'h9;
    step(4);
    pulse_go(8'h3C, 4'h8);
    pulse_en();
    wait_cmpl();
    chk_word(8'h3C, buf_q, "long setting means 8");
    chk_bit(1'b1, ovr, "overrun on unread");
  endtask
  task automatic slave_frames();
    read_clear();
    mode = 1'b0;
    bpf = 4'h8;
    step(2);
    chk_bit(1'b0, doe, "slave clock is input");
    pulse_en();
    pulse_go(8'h96, 4'h8);
    wait_cmpl();
    chk_word(8'h96, buf_q, "slave word");
    chk_bit(1'b1, flag, "enable kept");
    chk_bit(1'b0, ovr, "slave no overrun");
    // Partner holds its last phase for 22 cycles; a go pulse before that is lost
    step(24);
    pulse_go(8'h4D, 4'h8);
    wait_cmpl();
    chk_word(8'h4D, buf_q, "slave next frame");
    chk_bit(1'b1, ovr, "slave overrun");
    // Software clear of the kept enable flag
    en_clr = 1'b1;
    step(1);
    en_clr = 1'b0;
    chk_bit(1'b0, flag, "enable cleared by software");
  endtask
  task automatic drain_stream();
    logic [7:0] exp_q [5];
    int k;
    exp_q = '{8'hA5, 8'h0B, 8'h3C, 8'h96, 8'h4D};
    k = 0;
    s_rdy = 1'b1;
    for (int i = 0; i < 40; i++) begin
      if (s_val === 1'b1 && k < 5) begin
        chk_word(exp_q[k], s_data, "stream order");
        k++;
      end
      step(1);
    end
    chk_bit(1'b1, k == 5, "stream count");
    chk_bit(1'b0, s_val, "stream empty");
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clk);
    #1 nrst = 1'b1;
    step(6);
    master_basic();
    master_short_overrun();
    slave_frames();
    drain_stream();
    report_and_stop();
  end
endmodule
`default_nettype wire
